//--- design/rcr_pkg.sv
// Purpose: shared constants of the reset cause recorder
// Assumes: 32-bit classic Wishbone, 16-bit reset cause register
// Notes:   byte addresses; registers sit in the low bits of a word
`default_nettype none
package rcr_pkg;
   // register byte offsets
   localparam logic [7:0]  ADDR_CAUSE      = 8'h00;
   localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h08;
   localparam logic [7:0]  ADDR_PROT_LO    = 8'h0C;
   localparam logic [7:0]  ADDR_PROT_HI    = 8'h10;
   localparam logic [7:0]  ADDR_CTRL       = 8'h14;
   // reset cause register fields
   localparam int          BIT_POR         = 0;
   localparam int          BIT_BOR         = 1;
   localparam int          BIT_IDLE        = 2;
   localparam int          BIT_SLEEP       = 3;
   localparam int          BIT_WDOG        = 4;
   localparam int          BIT_SWRESET     = 6;
   localparam int          BIT_EXT         = 7;
   localparam int          BIT_MISMATCH    = 9;
   localparam int          BIT_ILLEGAL     = 14;
   localparam int          BIT_TRAP        = 15;
   localparam logic [15:0] CAUSE_IMPL      = 16'hC2DF;
   localparam logic [15:0] CAUSE_RST       = 16'h0003;
   // control register fields
   localparam int          CTRL_PROT_EN    = 0;
   localparam int          CTRL_MISM_EN    = 1;
   localparam logic [1:0]  CTRL_RST        = 2'b11;
   localparam logic [23:0] PROT_LO_RST     = 24'h00_0000;
   localparam logic [23:0] PROT_HI_RST     = 24'h00_0000;
   // trap priority levels
   localparam logic [3:0]  LVL_HARD_MIN    = 4'hD;
   localparam logic [3:0]  LVL_HARD_MAX    = 4'hF;
   localparam logic [3:0]  LVL_ADDR_ERR    = 4'hD;
   localparam logic [3:0]  LVL_OSC_FAIL    = 4'hE;
   // illegal opcode pattern in the upper instruction byte
   localparam logic [7:0]  OPC_ILLEGAL     = 8'h3F;
   // working registers and pin-select registers
   localparam int          WREG_NUM        = 16;
   localparam int          WREG_SP         = 15;
   localparam int          PPS_NUM         = 8;
   localparam int          PPS_W           = 16;
   // trap service state
   typedef enum logic [0:0] {
      TS_IDLE = 1'b0,
      TS_BUSY = 1'b1
   } rcr_trap_st_t;
endpackage
`default_nettype wire

//--- design/rcr_shadow_cmp.sv
// Purpose: shadow copy of the pin-select registers and mismatch detect
// Assumes: live cell contents arrive flattened, index 0 in the low bits
// Notes:   the shadow is loaded only by legal writes
`timescale 1ns/10ps
`default_nettype none
module rcr_shadow_cmp
   import rcr_pkg::*;
(
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     srst,
   // legal writes
   input  wire logic                     pps_wr_en,
   input  wire logic [2:0]               pps_wr_idx,
   input  wire logic [PPS_W-1:0]         pps_wr_data,
   // live cells and result
   input  wire logic [PPS_NUM*PPS_W-1:0] pps_live,
   output logic                          mismatch
);
   logic [PPS_W-1:0] shadow_q [PPS_NUM];
   logic [PPS_NUM-1:0] diff;

   genvar g;
   generate
      for (g = 0; g < PPS_NUM; g++) begin : g_sh
         always_ff @(posedge core_clk) begin
            if (srst) begin
               shadow_q[g] <= '0;
            end else if (pps_wr_en && pps_wr_idx == 3'(g)) begin
               shadow_q[g] <= pps_wr_data;
            end
         end
         // the write cycle itself is skipped: cell and shadow update together
         assign diff[g] = (pps_live[g*PPS_W +: PPS_W] != shadow_q[g])
                          && !(pps_wr_en && pps_wr_idx == 3'(g));
      end
   endgenerate

   assign mismatch = |diff;
endmodule
`default_nettype wire

//--- design/rcr_top.sv
// Purpose: reset cause recorder and illegal condition reset source
// Assumes: supervisor levels and reset pin are asynchronous; core inputs share core_clk
// Notes:   srst acts as the block's own power-on reset
`timescale 1ns/10ps
`default_nettype none
module rcr_top
   import rcr_pkg::*;
(
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     srst,
   // wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o,
   // asynchronous reset sources
   input  wire logic                     por_level,
   input  wire logic                     bor_level,
   input  wire logic                     external_reset_pin_n,
   // traps
   input  wire logic                     addr_err_trap,
   input  wire logic                     osc_fail_trap,
   input  wire logic                     hard_trap_req,
   input  wire logic [3:0]               hard_trap_level,
   input  wire logic                     trap_return,
   // instruction events
   input  wire logic                     opcode_exec,
   input  wire logic [23:0]              opcode_word,
   input  wire logic                     software_reset_exec,
   input  wire logic                     power_save_exec,
   input  wire logic                     power_save_idle,
   input  wire logic                     watchdog_clear_exec,
   input  wire logic                     watchdog_expire,
   input  wire logic                     core_in_power_save,
   // program counter reloads
   input  wire logic                     program_flow_change,
   input  wire logic                     vector_flow_change,
   input  wire logic [23:0]              pc_target,
   // working registers
   input  wire logic                     wreg_wr_en,
   input  wire logic [3:0]               wreg_wr_idx,
   input  wire logic                     wreg_ptr_use,
   input  wire logic [3:0]               wreg_ptr_idx,
   output logic [15:0]                   wreg_valid,
   // pin-select registers
   input  wire logic                     pps_wr_en,
   input  wire logic [2:0]               pps_wr_idx,
   input  wire logic [PPS_W-1:0]         pps_wr_data,
   input  wire logic [PPS_NUM*PPS_W-1:0] pps_live,
   // outputs
   output logic                          system_reset_signal,
   output logic                          irq
);
   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] lane16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
      lane16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic [23:0] lane24(input logic [23:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
      lane24 = {sel[2] ? wd[23:16] : old[23:16],
                sel[1] ? wd[15:8]  : old[15:8],
                sel[0] ? wd[7:0]   : old[7:0]};
   endfunction

   function automatic logic is_hard(input logic [3:0] lvl);
      is_hard = (lvl >= LVL_HARD_MIN) && (lvl <= LVL_HARD_MAX);
   endfunction

   // two-flop synchronisers for pins and supervisor levels
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync1_q <= 3'b000;
         sync2_q <= 3'b000;
      end else begin
         sync1_q <= {!external_reset_pin_n, bor_level, por_level};
         sync2_q <= sync1_q;
      end
   end
   wire por_s = sync2_q[0] || srst;
   wire bor_s = sync2_q[1];
   wire pin_s = sync2_q[2];

   // registers
   logic [15:0] cause_q;
   logic [15:0] cause_d;
   logic [15:0] istat_q;
   logic [15:0] istat_d;
   logic [15:0] imask_q;
   logic [23:0] prot_lo_q;
   logic [23:0] prot_hi_q;
   logic [1:0]  ctrl_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        sysreset_q;
   rcr_trap_st_t trap_st_q;
   logic [3:0]  trap_lvl_q;

   wire        trap_new = addr_err_trap || osc_fail_trap || hard_trap_req;
   wire [3:0]  trap_lvl = addr_err_trap ? LVL_ADDR_ERR :
                          osc_fail_trap ? LVL_OSC_FAIL : hard_trap_level;
   // lower hard trap while a higher one is serviced
   wire        trap_conflict = trap_new && is_hard(trap_lvl)
                               && (trap_st_q == TS_BUSY) && (trap_lvl < trap_lvl_q);

   always_ff @(posedge core_clk) begin
      if (srst || sysreset_q) begin
         trap_st_q  <= TS_IDLE;
         trap_lvl_q <= 4'h0;
      end else begin
         case (trap_st_q)
            TS_IDLE: begin
               if (trap_new) begin
                  trap_st_q  <= TS_BUSY;
                  trap_lvl_q <= trap_lvl;
               end
            end
            TS_BUSY: begin
               if (trap_return) begin
                  trap_st_q <= TS_IDLE;
               end else if (trap_new && trap_lvl > trap_lvl_q) begin
                  trap_lvl_q <= trap_lvl;
               end
            end
            default: trap_st_q <= TS_IDLE;
         endcase
      end
   end

   logic mismatch;
   rcr_shadow_cmp u_shadow (
      .core_clk    (core_clk),
      .srst        (srst),
      .pps_wr_en   (pps_wr_en),
      .pps_wr_idx  (pps_wr_idx),
      .pps_wr_data (pps_wr_data),
      .pps_live    (pps_live),
      .mismatch    (mismatch)
   );
   wire mism_event = mismatch && ctrl_q[CTRL_MISM_EN];

   logic uninit_fault;
   rcr_wreg_track u_wreg (
      .core_clk     (core_clk),
      .srst         (srst),
      .sys_reset    (sysreset_q),
      .wreg_wr_en   (wreg_wr_en),
      .wreg_wr_idx  (wreg_wr_idx),
      .wreg_ptr_use (wreg_ptr_use),
      .wreg_ptr_idx (wreg_ptr_idx),
      .wreg_valid   (wreg_valid),
      .uninit_fault (uninit_fault)
   );

   wire illegal_op = opcode_exec && (opcode_word[23:16] == OPC_ILLEGAL);
   // any pc reload into protected range other than its entry
   wire in_prot = (pc_target >= prot_lo_q) && (pc_target <= prot_hi_q)
                  && (pc_target != prot_lo_q);
   wire security = ctrl_q[CTRL_PROT_EN] && in_prot
                   && (program_flow_change || vector_flow_change);
   wire illegal_event = illegal_op || uninit_fault || security;
   // watchdog during power save wakes the core rather than resetting it
   wire wdt_reset = watchdog_expire && !core_in_power_save;

   // hardware set and clear terms of the cause register
   logic [15:0] hw_set;
   logic [15:0] hw_clr;
   always_comb begin
      hw_set = 16'h0000;
      hw_clr = 16'h0000;
      hw_set[BIT_TRAP]    = trap_conflict;
      hw_set[BIT_MISMATCH] = mism_event;
      hw_set[BIT_ILLEGAL] = illegal_event;
      hw_set[BIT_SWRESET] = software_reset_exec;
      hw_set[BIT_WDOG]    = watchdog_expire;
      hw_clr[BIT_WDOG]    = power_save_exec || watchdog_clear_exec;
      hw_set[BIT_SLEEP]   = power_save_exec && !power_save_idle;
      hw_set[BIT_IDLE]    = power_save_exec && power_save_idle;
      hw_set[BIT_EXT]     = pin_s;
      hw_set[BIT_POR]     = por_s;
      hw_set[BIT_BOR]     = por_s || bor_s;
   end

   // bus decode
   wire        bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
   wire        bus_wr   = bus_req && wb_we_i;
   wire        sel_cause = wb_adr_i == ADDR_CAUSE;
   wire        sel_istat = wb_adr_i == ADDR_IRQ_STAT;
   wire        sel_imask = wb_adr_i == ADDR_IRQ_MASK;
   wire        sel_plo   = wb_adr_i == ADDR_PROT_LO;
   wire        sel_phi   = wb_adr_i == ADDR_PROT_HI;
   wire        sel_ctrl  = wb_adr_i == ADDR_CTRL;
   wire [31:0] rd_mux =
      sel_cause ? {16'h0000, cause_q} :
      sel_istat ? {16'h0000, istat_q} :
      sel_imask ? {16'h0000, imask_q} :
      sel_plo   ? {8'h00, prot_lo_q}  :
      sel_phi   ? {8'h00, prot_hi_q}  :
      sel_ctrl  ? {30'h0000_0000, ctrl_q} : 32'h0000_0000;

   // software write, then hardware sets win over it
   wire [15:0] sw_cause = (bus_wr && sel_cause) ?
                          lane16(cause_q, wb_dat_i, wb_sel_i) : cause_q;
   // POR clears all; BOR clears all but the pin flag and the power-on flag
   wire [15:0] keep = por_s ? 16'h0000 :
                      bor_s ? (16'h0001 << BIT_EXT) | (16'h0001 << BIT_POR) : 16'hFFFF;
   assign cause_d = (((sw_cause & ~hw_clr) & keep) | hw_set) & CAUSE_IMPL;

   // interrupt status: write one to clear, new event wins
   wire [15:0] ev_rise = hw_set & ~cause_q;
   wire [15:0] w1c = (bus_wr && sel_istat) ?
                     lane16(16'h0000, wb_dat_i, wb_sel_i) : 16'h0000;
   assign istat_d = ((istat_q & ~w1c) | ev_rise) & CAUSE_IMPL;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cause_q <= CAUSE_RST;
      end else begin
         cause_q <= cause_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         istat_q <= 16'h0000;
      end else begin
         istat_q <= istat_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         imask_q   <= 16'h0000;
         prot_lo_q <= PROT_LO_RST;
         prot_hi_q <= PROT_HI_RST;
         ctrl_q    <= CTRL_RST;
      end else if (bus_wr) begin
         if (sel_imask) imask_q   <= lane16(imask_q, wb_dat_i, wb_sel_i) & CAUSE_IMPL;
         if (sel_plo)   prot_lo_q <= lane24(prot_lo_q, wb_dat_i, wb_sel_i);
         if (sel_phi)   prot_hi_q <= lane24(prot_hi_q, wb_dat_i, wb_sel_i);
         if (sel_ctrl && wb_sel_i[0]) ctrl_q <= wb_dat_i[1:0];
      end
   end

   // one-cycle ack; unmapped addresses answer with zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= bus_req;
         rdat_q <= bus_req ? rd_mux : rdat_q;
      end
   end

   // any reset cause pulses the system reset, which re-clears the tracker
   wire any_reset = trap_conflict || mism_event || illegal_event || software_reset_exec
                    || wdt_reset || pin_s || bor_s || sync2_q[0];
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sysreset_q <= 1'b1;
      end else begin
         sysreset_q <= any_reset;
      end
   end

   assign wb_ack_o            = ack_q;
   assign wb_dat_o            = rdat_q;
   assign system_reset_signal = sysreset_q;
   assign irq                 = |(istat_q & imask_q);
endmodule
`default_nettype wire

//--- design/rcr_wreg_track.sv
// Purpose: tracks which working registers have been written since reset
// Assumes: the stack pointer register is never uninitialized
// Notes:   fault is combinational so the pointer use is caught at once
`timescale 1ns/10ps
`default_nettype none
module rcr_wreg_track
   import rcr_pkg::*;
(
   // clock and resets
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       sys_reset,
   // register file activity
   input  wire logic       wreg_wr_en,
   input  wire logic [3:0] wreg_wr_idx,
   input  wire logic       wreg_ptr_use,
   input  wire logic [3:0] wreg_ptr_idx,
   // status
   output logic [15:0]     wreg_valid,
   output logic            uninit_fault
);
   logic [WREG_NUM-1:0] valid_q;

   genvar g;
   generate
      for (g = 0; g < WREG_NUM; g++) begin : g_v
         always_ff @(posedge core_clk) begin
            if (srst || sys_reset) begin
               valid_q[g] <= (g == WREG_SP);
            end else if (wreg_wr_en && wreg_wr_idx == 4'(g)) begin
               valid_q[g] <= 1'b1;
            end
         end
      end
   endgenerate

   assign wreg_valid = valid_q;
   assign uninit_fault = wreg_ptr_use && !valid_q[wreg_ptr_idx];
endmodule
`default_nettype wire

//--- tb/rcr_core_model.sv
// Purpose: behavioural core and trap logic facing the recorder
// Assumes: one event pulse per call, taken at the following edge
// Notes:   shared argument feeds opcode, target, level and index
`timescale 1ns/10ps
`default_nettype none
module rcr_core_model (
   // clock
   input  wire logic core_clk,
   // traps
   output logic        addr_err_trap,
   output logic        osc_fail_trap,
   output logic        hard_trap_req,
   output logic [3:0]  hard_trap_level,
   output logic        trap_return,
   // instructions
   output logic        opcode_exec,
   output logic [23:0] opcode_word,
   output logic        software_reset_exec,
   output logic        power_save_exec,
   output logic        power_save_idle,
   output logic        watchdog_clear_exec,
   output logic        watchdog_expire,
   // flow changes and register file
   output logic        program_flow_change,
   output logic        vector_flow_change,
   output logic [23:0] pc_target,
   output logic        wreg_wr_en,
   output logic [3:0]  wreg_wr_idx,
   output logic        wreg_ptr_use,
   output logic [3:0]  wreg_ptr_idx
);
   logic [12:0] ev_q  = 13'h0000;
   logic [23:0] arg_q = 24'h00_0000;
   assign {wreg_ptr_use, wreg_wr_en, vector_flow_change, program_flow_change} = ev_q[12:9];
   assign {watchdog_expire, watchdog_clear_exec, power_save_exec} = ev_q[8:6];
   assign {software_reset_exec, opcode_exec, trap_return} = ev_q[5:3];
   assign {hard_trap_req, osc_fail_trap, addr_err_trap} = ev_q[2:0];
   assign opcode_word     = arg_q;
   assign pc_target       = arg_q;
   assign hard_trap_level = arg_q[3:0];
   assign wreg_wr_idx     = arg_q[3:0];
   assign wreg_ptr_idx    = arg_q[3:0];
   assign power_save_idle = arg_q[0];
   task automatic ev(input int b, input logic [23:0] a);
      @(posedge core_clk);
      ev_q  <= 13'h0001 << b;
      arg_q <= a;
   endtask
   // qualifiers flip when idle so a stale value is never trusted
   task automatic idle();
      @(posedge core_clk);
      ev_q  <= 13'h0000;
      arg_q <= ~arg_q;
   endtask
endmodule
`default_nettype wire

//--- tb/rcr_top_monitor.sv
// Purpose: port-level checks of the reset cause recorder
// Assumes: every input changes just after a core_clk edge
// Notes:   bound into each rcr_top instance
`timescale 1ns/10ps
`default_nettype none
module rcr_top_monitor
   import rcr_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        srst,
   // register bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_ack_o,
   // core events
   input  wire logic        addr_err_trap,
   input  wire logic        osc_fail_trap,
   input  wire logic        trap_return,
   input  wire logic        opcode_exec,
   input  wire logic [23:0] opcode_word,
   input  wire logic        software_reset_exec,
   input  wire logic        watchdog_expire,
   input  wire logic        core_in_power_save,
   // working registers
   input  wire logic        wreg_wr_en,
   input  wire logic [3:0]  wreg_wr_idx,
   input  wire logic        wreg_ptr_use,
   input  wire logic [3:0]  wreg_ptr_idx,
   input  wire logic [15:0] wreg_valid,
   // results
   input  wire logic        system_reset_signal,
   input  wire logic        irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
   property p_swr;
      software_reset_exec |=> system_reset_signal;
   endproperty
   a_swr: assert property (p_swr) else $error("no reset after reset instruction");
   property p_opc;
      opcode_exec && opcode_word[23:16] == OPC_ILLEGAL |=> system_reset_signal;
   endproperty
   a_opc: assert property (p_opc) else $error("illegal opcode not reset");
   property p_wdt;
      watchdog_expire && !core_in_power_save |=> system_reset_signal;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog expiry not reset");
   // a same-cycle write to that register is left out here, though the tracker still faults on it
   property p_uninit;
      wreg_ptr_use && !wreg_valid[wreg_ptr_idx]
         && !(wreg_wr_en && wreg_wr_idx == wreg_ptr_idx) |=> system_reset_signal;
   endproperty
   a_uninit: assert property (p_uninit) else $error("unwritten pointer not reset");
   property p_wclear;
      system_reset_signal |=> wreg_valid == 16'h8000;
   endproperty
   a_wclear: assert property (p_wclear) else $error("registers not cleared");
   property p_trap;
      (osc_fail_trap && !addr_err_trap && !system_reset_signal)
         ##1 (addr_err_trap && !trap_return && !system_reset_signal) |=> system_reset_signal;
   endproperty
   a_trap: assert property (p_trap) else $error("trap conflict not reset");
   property p_irq_rst;
      $fell(srst) |-> !irq;
   endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
endmodule
bind rcr_top rcr_top_monitor u_mon (.*);
`default_nettype wire

//--- tb/rcr_top_tb.sv
// Purpose: self-checking bench of the reset cause recorder
// Assumes: classic single Wishbone cycles, one per call
// Notes:   the core side is played by rcr_core_model
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module rcr_top_tb;
   import rcr_pkg::*;
   logic                     core_clk = 1'b0;
   logic                     srst = 1'b1;
   logic                     wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]               wb_adr_i = 8'h00;
   logic [3:0]               wb_sel_i = 4'h0;
   logic [31:0]              wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic                     wb_ack_o, system_reset_signal, irq;
   logic                     por_level = 1'b0, bor_level = 1'b0, external_reset_pin_n = 1'b1;
   logic                     core_in_power_save = 1'b0, pps_wr_en = 1'b0;
   logic [2:0]               pps_wr_idx = 3'h0;
   logic [PPS_W-1:0]         pps_wr_data = 16'h0000;
   logic [PPS_NUM*PPS_W-1:0] pps_live = '0;
   logic [15:0]              wreg_valid;
   logic                     addr_err_trap, osc_fail_trap, hard_trap_req, trap_return;
   logic                     opcode_exec, software_reset_exec, power_save_exec, power_save_idle;
   logic                     watchdog_clear_exec, watchdog_expire, program_flow_change;
   logic                     vector_flow_change, wreg_wr_en, wreg_ptr_use;
   logic [3:0]               hard_trap_level, wreg_wr_idx, wreg_ptr_idx;
   logic [23:0]              opcode_word, pc_target;
   int                       mismatches = 0, tests_run = 0;
   int                       eb[11] = '{5, 8, 6, 6, 4, 4, 12, 9, 9, 10, 9};
   logic [23:0]              ea[11] = '{24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0001,
      24'h3F_0000, 24'h3E_FFFF, 24'h00_0003, 24'h00_1000, 24'h00_1800, 24'h00_1800, 24'h00_2000};
   logic [15:0]              ex[11] = '{16'h0040, 16'h0010, 16'h0008, 16'h0004, 16'h4000,
      16'h0000, 16'h4000, 16'h0000, 16'h4000, 16'h4000, 16'h0000};

   always #2 core_clk = ~core_clk;
   rcr_top dut (.*);
   rcr_core_model cpu (.*);

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         $display("MISMATCH t=%0t no ack", $time);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
   endtask
   // drives por, bor and the pin as one field, held long enough to pass the synchronisers
   task automatic lvl(input logic [2:0] k);
      @(posedge core_clk);
      {por_level, bor_level, external_reset_pin_n} <= k;
      repeat (4) @(posedge core_clk);
      {por_level, bor_level, external_reset_pin_n} <= 3'b001;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic report_and_stop();
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      $display("MISMATCH t=%0t run too long", $time);
      report_and_stop();
   end

   initial begin
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      rc(ADDR_CAUSE, 32'h0000_0003);
      rc(ADDR_IRQ_STAT, 32'h0000_0000);
      rc(ADDR_IRQ_MASK, 32'h0000_0000);
      rc(ADDR_CTRL, 32'h0000_0003);
      rc(8'h40, 32'h0000_0000);
      wb(1'b1, ADDR_CAUSE, 32'h0000_FFFF);
      rc(ADDR_CAUSE, 32'h0000_C2DF);
      wb(1'b1, ADDR_CAUSE, 32'h0000_0000);
      rc(ADDR_CAUSE, 32'h0000_0000);
      $display("test registers done");
      wb(1'b1, ADDR_PROT_LO, 32'h0000_1000);
      wb(1'b1, ADDR_PROT_HI, 32'h0000_1FFF);
      for (int i = 0; i < 11; i++) begin
         cpu.ev(eb[i], ea[i]);
         cpu.idle();
         rc(ADDR_CAUSE, {16'h0000, ex[i]});
         wb(1'b1, ADDR_CAUSE, 32'h0000_0000);
      end
      rc(ADDR_PROT_HI, 32'h0000_1FFF);
      wb(1'b1, ADDR_CTRL, 32'h0000_0000);
      cpu.ev(9, 24'h00_1800);
      cpu.idle();
      rc(ADDR_CAUSE, 32'h0000_0000);
      wb(1'b1, ADDR_CTRL, 32'h0000_0003);
      cpu.ev(8, 24'h00_0000);
      cpu.ev(7, 24'h00_0000);
      cpu.idle();
      rc(ADDR_CAUSE, 32'h0000_0000);
      cpu.ev(8, 24'h00_0000);
      cpu.ev(6, 24'h00_0001);
      cpu.idle();
      rc(ADDR_CAUSE, 32'h0000_0004);
      wb(1'b1, ADDR_CAUSE, 32'h0000_0000);
      `CHK(wreg_valid, 16'h8000)
      cpu.ev(11, 24'h00_0003);
      cpu.idle();
      cpu.ev(12, 24'h00_0003);
      cpu.idle();
      rc(ADDR_CAUSE, 32'h0000_0000);
      `CHK(wreg_valid, 16'h8008)
      $display("test events done");
      cpu.ev(1, 24'h00_0000);
      cpu.ev(0, 24'h00_0000);
      cpu.idle();
      rc(ADDR_CAUSE, 32'h0000_8000);
      wb(1'b1, ADDR_CAUSE, 32'h0000_0000);
      cpu.ev(0, 24'h00_0000);
      cpu.ev(1, 24'h00_0000);
      cpu.ev(3, 24'h00_0000);
      cpu.ev(2, 24'h00_000F);
      cpu.ev(2, 24'h00_000C);
      cpu.ev(3, 24'h00_0000);
      cpu.idle();
      rc(ADDR_CAUSE, 32'h0000_0000);
      cpu.ev(2, 24'h00_000F);
      cpu.ev(1, 24'h00_0000);
      cpu.idle();
      rc(ADDR_CAUSE, 32'h0000_8000);
      wb(1'b1, ADDR_CAUSE, 32'h0000_0000);
      $display("test traps done");
      @(posedge core_clk);
      pps_wr_en <= 1'b1;
      pps_wr_idx <= 3'h2;
      pps_wr_data <= 16'h00A5;
      pps_live[47:32] <= 16'h00A5;
      @(posedge core_clk);
      pps_wr_en <= 1'b0;
      rc(ADDR_CAUSE, 32'h0000_0000);
      pps_live[47:32] <= 16'h00A4;
      rc(ADDR_CAUSE, 32'h0000_0200);
      pps_live[47:32] <= 16'h00A5;
      wb(1'b1, ADDR_CAUSE, 32'h0000_0000);
      $display("test mismatch done");
      wb(1'b1, ADDR_IRQ_STAT, 32'h0000_FFFF);
      wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0040);
      `CHK(irq, 1'b0)
      cpu.ev(5, 24'h00_0000);
      cpu.idle();
      rc(ADDR_CAUSE, 32'h0000_0040);
      `CHK(irq, 1'b1)
      `CHK(wreg_valid, 16'h8000)
      wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
      `CHK(irq, 1'b0)
      wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0040);
      rc(ADDR_IRQ_STAT, 32'h0000_0040);
      `CHK(irq, 1'b1)
      wb(1'b1, ADDR_IRQ_STAT, 32'h0000_0040);
      `CHK(irq, 1'b0)
      $display("test interrupt done");
      lvl(3'b000);
      rc(ADDR_CAUSE, 32'h0000_00C0);
      lvl(3'b011);
      rc(ADDR_CAUSE, 32'h0000_0082);
      lvl(3'b101);
      rc(ADDR_CAUSE, 32'h0000_0003);
      $display("test supervisors done");
      report_and_stop();
   end
endmodule
`default_nettype wire
